//--- rcs_reset_clock_sequencer.sv
// Reset sequencer, bus clock enables and reset cause register.
`timescale 1ns/100ps
module rcs_reset_clock_sequencer #(
  parameter int POWER_ON_COUNT = rcs_pkg::POWER_ON_CYCLES,
  parameter int STOP_LONG_COUNT = rcs_pkg::STOP_LONG_CYCLES,
  parameter int PIN_POWER_COUNT = rcs_pkg::PIN_MIN_POWER_CYCLES
) (
  // Clock and power-on reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Reset sources and stop, wait and wake inputs.
  input wire logic powerOnPulse,
  input wire logic lowVoltageDetect,
  input wire logic watchdogOverflow,
  input wire logic badOpcode,
  input wire logic stopInstr,
  input wire logic waitInstr,
  input wire logic wakeEvent,
  input wire logic opcodeFetch,
  input wire logic unmappedAccess,
  // Open-drain reset pin.
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  // Clock enables and reset to the core.
  output logic clockGenEnable,
  output logic busClkEn,
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic internalReset,
  output logic [15:0] resetVector,
  output logic watchdogClkEn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    rcs_pkg::rcs_state_t state;
    logic [12:0] seqCount;
    logic [12:0] pinLowCount;
    logic [11:0] simCounter;
    logic [1:0] clkGenDiv;
    logic busPhase;
    logic wdgEvent;
    logic powerCause;
    logic waiting;
    logic [1:0] pinSync;
    logic [7:0] cause;
    logic [7:0] settings;
    logic breakWait;
    logic breakClearEn;
    logic [31:0] rdata;
    logic [15:0] vector;
  } rcs_regs_t;

  rcs_regs_t r_reg;
  rcs_regs_t r_next;
  logic pinLow;
  logic lvReset;
  logic wdgReset;
  logic illegalOp;
  logic illegalAddr;
  logic apbAccess;
  logic faultReset;
  logic genTick;
  logic busTick;
  logic [12:0] pinFlagCount;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] causeOnly(input int bit_pos);
    causeOnly = 8'h00;
    causeOnly[bit_pos] = 1'b1;
  endfunction : causeOnly

  // Decodes the mapped register words for the error flag; reads decode them again in regRead.
  function automatic logic isMapped(input logic [15:0] addr);
    isMapped = 1'b0;
    case (addr)
      rcs_pkg::ADDR_BREAK_STATUS: isMapped = 1'b1;
      rcs_pkg::ADDR_RESET_CAUSE: isMapped = 1'b1;
      rcs_pkg::ADDR_BREAK_FLAG_CTRL: isMapped = 1'b1;
      rcs_pkg::ADDR_CONFIG: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction : isMapped

  // A new fault reset replaces the old cause so software sees one story.
  function automatic logic [7:0] faultCause(input logic wdg,
      input logic op, input logic addr);
    faultCause = 8'h00;
    faultCause[rcs_pkg::CAUSE_WATCHDOG] = wdg;
    faultCause[rcs_pkg::CAUSE_BAD_OPCODE] = op;
    faultCause[rcs_pkg::CAUSE_BAD_ADDRESS] = addr;
  endfunction : faultCause

  // Recovery length picked by the short-stop option.
  function automatic logic [12:0] stopDelay(input logic shortStop);
    stopDelay = shortStop ? 13'(rcs_pkg::STOP_SHORT_CYCLES) :
      13'(STOP_LONG_COUNT);
  endfunction : stopDelay

  // Read value of one register word; unmapped words read as zero.
  function automatic logic [31:0] regRead(input logic [15:0] addr,
      input rcs_regs_t regs);
    regRead = 32'h0000_0000;
    case (addr)
      rcs_pkg::ADDR_BREAK_STATUS:
        regRead[rcs_pkg::BREAK_WAIT_BIT] = regs.breakWait;
      rcs_pkg::ADDR_RESET_CAUSE: regRead[7:0] = regs.cause;
      rcs_pkg::ADDR_BREAK_FLAG_CTRL:
        regRead[rcs_pkg::BREAK_CLEAR_EN_BIT] = regs.breakClearEn;
      rcs_pkg::ADDR_CONFIG: regRead[7:0] = regs.settings;
      default: regRead = 32'h0000_0000;
    endcase
  endfunction : regRead

  //////////////////////////////////////////////////////////////////////////
  // Watchdog event is caught on its own edge, not on the bus clock.
  logic wdgSeen;
  always_ff @(posedge watchdogOverflow or negedge reset_n) begin
    if (!reset_n) begin
      wdgSeen <= 1'b0;
    end else begin
      wdgSeen <= ~wdgSeen;
    end
  end

  assign pinLow = ~r_reg.pinSync[1];
  assign lvReset = lowVoltageDetect &
    ~r_reg.settings[rcs_pkg::CFG_LV_POWERDOWN] &
    ~r_reg.settings[rcs_pkg::CFG_LV_RESET_DISABLE];
  assign wdgReset = (wdgSeen != r_reg.wdgEvent) &
    ~r_reg.settings[rcs_pkg::CFG_WATCHDOG_DISABLE];
  assign illegalOp = badOpcode |
    (stopInstr & ~r_reg.settings[rcs_pkg::CFG_STOP_ENABLE]);
  assign illegalAddr = opcodeFetch & unmappedAccess;
  assign faultReset = wdgReset | illegalOp | illegalAddr;
  assign apbAccess = psel & penable;
  // Only the reference clock reaches this block, so a selected PLL source
  // runs at the same rate here; software still reads its selection back.
  assign genTick = r_reg.clkGenDiv[0];
  assign busTick = genTick & r_reg.busPhase;
  // A pin held low during a power reset must stay low for the longer time.
  assign pinFlagCount = r_reg.powerCause ? 13'(PIN_POWER_COUNT) :
    13'(rcs_pkg::PIN_MIN_CYCLES);

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    r_next.pinSync = {r_reg.pinSync[0], resetPinIn};
    r_next.wdgEvent = wdgSeen;
    // Generator tick every second cycle, bus enable on every second tick.
    r_next.clkGenDiv = r_reg.clkGenDiv + 2'h1;
    if (genTick) begin
      r_next.busPhase = ~r_reg.busPhase;
    end
    // Twelve-bit counter runs, cleared on stop entry and on fault and low-voltage resets; its wrap gives the watchdog tick.
    r_next.simCounter = r_reg.simCounter + 12'h001;
    if (r_reg.seqCount != 13'h0000) begin
      r_next.seqCount = r_reg.seqCount - 13'h0001;
    end
    if (pinLow) begin
      if (r_reg.pinLowCount != 13'h1FFF) begin
        r_next.pinLowCount = r_reg.pinLowCount + 13'h0001;
      end
    end else begin
      r_next.pinLowCount = 13'h0000;
    end
    case (r_reg.state)
      rcs_pkg::ST_RUN, rcs_pkg::ST_STOP: begin
        if (r_reg.state == rcs_pkg::ST_STOP && wakeEvent) begin
          r_next.state = rcs_pkg::ST_STOP_RECOVER;
          r_next.seqCount = stopDelay(
            r_reg.settings[rcs_pkg::CFG_SHORT_STOP]);
        end
        if (r_reg.state == rcs_pkg::ST_RUN && stopInstr &&
            r_reg.settings[rcs_pkg::CFG_STOP_ENABLE]) begin
          r_next.state = rcs_pkg::ST_STOP;
          r_next.simCounter = 12'h000;
        end
        r_next.waiting = (r_reg.waiting | waitInstr) & ~wakeEvent;
        if (lvReset) begin
          r_next.cause = causeOnly(rcs_pkg::CAUSE_LOW_VOLTAGE);
          r_next.state = rcs_pkg::ST_POWER_HOLD;
          r_next.seqCount = 13'(POWER_ON_COUNT);
          r_next.powerCause = 1'b1;
          r_next.simCounter = 12'h000;
        end else if (faultReset) begin
          r_next.cause = faultCause(wdgReset, illegalOp, illegalAddr);
          r_next.state = rcs_pkg::ST_PIN_DRIVE;
          r_next.seqCount = 13'(rcs_pkg::PIN_HOLD_CYCLES);
          r_next.powerCause = 1'b0;
          r_next.simCounter = 12'h000;
        end else if (pinLow) begin
          r_next.state = rcs_pkg::ST_EXT_PIN;
          r_next.powerCause = 1'b0;
        end
      end
      rcs_pkg::ST_POWER_HOLD: begin
        if (r_reg.seqCount <= 13'h0001) begin
          r_next.state = rcs_pkg::ST_RELEASE;
          r_next.seqCount = 13'(rcs_pkg::POWER_ON_TAIL);
        end
      end
      rcs_pkg::ST_PIN_DRIVE: begin
        if (r_reg.seqCount <= 13'h0001) begin
          r_next.state = rcs_pkg::ST_RELEASE;
          r_next.seqCount = 13'(rcs_pkg::RELEASE_CYCLES);
        end
      end
      rcs_pkg::ST_RELEASE: begin
        if (r_reg.seqCount <= 13'h0001 && !pinLow) begin
          r_next.state = rcs_pkg::ST_RUN;
          r_next.powerCause = 1'b0;
        end
      end
      rcs_pkg::ST_EXT_PIN: begin
        // Counter is left alone here: a pin reset does not touch it.
        if (!pinLow) begin
          r_next.state = rcs_pkg::ST_RUN;
        end
      end
      default: begin
        if (r_reg.seqCount <= 13'h0001) begin
          r_next.state = rcs_pkg::ST_RUN;
        end
      end
    endcase
    // Pin flag qualifies on how long the pin stays low.
    if (r_reg.pinLowCount == pinFlagCount) begin
      r_next.cause = causeOnly(rcs_pkg::CAUSE_PIN);
    end
    // Register access; the reset cause register is read only.
    r_next.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      r_next.rdata = regRead(paddr, r_reg);
    end
    if (apbAccess && pwrite) begin
      case (paddr)
        rcs_pkg::ADDR_BREAK_STATUS: begin
          if (!pwdata[rcs_pkg::BREAK_WAIT_BIT]) begin
            r_next.breakWait = 1'b0;
          end
        end
        rcs_pkg::ADDR_BREAK_FLAG_CTRL:
          r_next.breakClearEn = pwdata[rcs_pkg::BREAK_CLEAR_EN_BIT];
        rcs_pkg::ADDR_CONFIG: r_next.settings = pwdata[7:0];
        default: r_next.settings = r_next.settings;
      endcase
    end
    // Any wait entry sets the flag; the set wins over a clear.
    if (waitInstr) begin
      r_next.breakWait = 1'b1;
    end
    // Watchdog, fault and low-voltage resets bring registers back, cause flags kept.
    if ((r_reg.state == rcs_pkg::ST_PIN_DRIVE &&
        r_reg.seqCount == 13'(rcs_pkg::PIN_HOLD_CYCLES)) ||
        (r_reg.state == rcs_pkg::ST_POWER_HOLD &&
        r_reg.seqCount == 13'(POWER_ON_COUNT))) begin
      r_next.settings = rcs_pkg::CONFIG_RESET;
      r_next.breakWait = 1'b0;
      r_next.breakClearEn = 1'b0;
      r_next.waiting = 1'b0;
    end
    // The vector is registered so the core never sees a decode glitch.
    r_next.vector = r_next.settings[rcs_pkg::CFG_MONITOR] ?
      rcs_pkg::VECTOR_MONITOR : rcs_pkg::VECTOR_USER;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Power-on: only the power-on flag set, long hold started.
      r_reg <= '0;
      r_reg.state <= rcs_pkg::ST_POWER_HOLD;
      r_reg.seqCount <= 13'(POWER_ON_COUNT);
      r_reg.powerCause <= 1'b1;
      r_reg.cause <= rcs_pkg::CAUSE_RESET;
      r_reg.settings <= rcs_pkg::CONFIG_RESET;
      r_reg.vector <= rcs_pkg::VECTOR_USER;
      r_reg.pinSync <= 2'h3;
    end else if (powerOnPulse) begin
      r_reg <= '0;
      r_reg.state <= rcs_pkg::ST_POWER_HOLD;
      r_reg.seqCount <= 13'(POWER_ON_COUNT);
      r_reg.powerCause <= 1'b1;
      r_reg.cause <= causeOnly(rcs_pkg::CAUSE_POWER_ON);
      r_reg.vector <= rcs_pkg::VECTOR_USER;
      r_reg.pinSync <= r_next.pinSync;
      r_reg.wdgEvent <= r_next.wdgEvent;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  logic running;
  logic inPowerHold;
  logic inPinDrive;
  logic inStopped;
  assign running = (r_reg.state == rcs_pkg::ST_RUN);
  assign inPowerHold = (r_reg.state == rcs_pkg::ST_POWER_HOLD);
  assign inPinDrive = (r_reg.state == rcs_pkg::ST_PIN_DRIVE);
  assign inStopped = (r_reg.state == rcs_pkg::ST_STOP) |
    (r_reg.state == rcs_pkg::ST_STOP_RECOVER);
  // The pin is open drain: only a low level is ever driven onto it.
  assign resetPinOut = 1'b0;
  assign resetPinOe = inPowerHold | inPinDrive;
  assign clockGenEnable = 1'b1;
  assign busClkEn = running & busTick;
  assign cpuClkEn = busClkEn & ~r_reg.waiting;
  // Peripherals keep their enable in wait; each gates itself if it must.
  assign periphClkEn = busClkEn;
  // Stop is not a reset, so the core sees no reset while clocks are off.
  assign internalReset = ~running & ~inStopped;
  assign resetVector = r_reg.vector;
  assign watchdogClkEn = (r_reg.simCounter == 12'hFFF);
  assign prdata = r_reg.rdata;
  // Every access completes in its first access cycle, with no wait states.
  assign pready = 1'b1;
  assign pslverr = apbAccess & ~isMapped(paddr);
endmodule : rcs_reset_clock_sequencer

//--- rcs_pkg.sv
// Package of constants and types for the reset and clock sequencer.
package rcs_pkg;
  // Register byte addresses on the APB slave.
  localparam logic [15:0] ADDR_BREAK_STATUS = 16'hFE00;
  localparam logic [15:0] ADDR_RESET_CAUSE = 16'hFE01;
  localparam logic [15:0] ADDR_BREAK_FLAG_CTRL = 16'hFE03;
  localparam logic [15:0] ADDR_CONFIG = 16'hFE04;
  // Field positions in the reset cause register.
  localparam int CAUSE_POWER_ON = 7;
  localparam int CAUSE_PIN = 6;
  localparam int CAUSE_WATCHDOG = 5;
  localparam int CAUSE_BAD_OPCODE = 4;
  localparam int CAUSE_BAD_ADDRESS = 3;
  localparam int CAUSE_LOW_VOLTAGE = 1;
  // Field positions elsewhere.
  localparam int BREAK_WAIT_BIT = 1;
  localparam int BREAK_CLEAR_EN_BIT = 7;
  localparam int CFG_WATCHDOG_DISABLE = 0;
  localparam int CFG_LV_POWERDOWN = 1;
  localparam int CFG_LV_RESET_DISABLE = 2;
  localparam int CFG_SHORT_STOP = 3;
  localparam int CFG_STOP_ENABLE = 4;
  localparam int CFG_USE_PLL = 5;
  localparam int CFG_MONITOR = 6;
  // Reset values.
  localparam logic [7:0] CAUSE_RESET = 8'h80;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // Timing counts in reference clock cycles.
  localparam int PIN_HOLD_CYCLES = 32;
  localparam int RELEASE_CYCLES = 32;
  localparam int POWER_ON_CYCLES = 4096;
  localparam int POWER_ON_TAIL = 64;
  localparam int PIN_MIN_CYCLES = 67;
  localparam int PIN_MIN_POWER_CYCLES = 4163;
  localparam int STOP_LONG_CYCLES = 4096;
  localparam int STOP_SHORT_CYCLES = 32;
  localparam int CLK_GEN_DIVIDE = 4;
  localparam int BUS_DIVIDE = 2;
  // Reset vectors.
  localparam logic [15:0] VECTOR_USER = 16'hFFFE;
  localparam logic [15:0] VECTOR_MONITOR = 16'hFEFE;
  typedef enum {
    ST_RUN, ST_POWER_HOLD, ST_PIN_DRIVE, ST_RELEASE, ST_EXT_PIN, ST_STOP,
    ST_STOP_RECOVER
  } rcs_state_t;
endpackage : rcs_pkg

//--- rcs_checker.sv
// Concurrent checks on the reset sequencer ports.
`timescale 1ns/100ps
module rcs_checker #(
  parameter int POWER_ON_COUNT = rcs_pkg::POWER_ON_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Fault inputs.
  input wire logic badOpcode,
  input wire logic opcodeFetch,
  input wire logic unmappedAccess,
  // Pin and core outputs.
  input wire logic resetPinIn,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic busClkEn,
  input wire logic cpuClkEn,
  input wire logic periphClkEn,
  input wire logic internalReset,
  input wire logic watchdogClkEn
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  int oeCount;
  // The drive length is counted here because it is far above eight cycles.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      oeCount <= 0;
    end else begin
      oeCount <= resetPinOe ? oeCount + 1 : 0;
    end
  end
  sequence faultDrive;
    ##[1:4] resetPinOe;
  endsequence
  sequence releaseTail;
    ##30 internalReset;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  pin_out_low_a: assert property (resetPinOut == 1'b0)
    else $error("Reset pin driven high");
  pin_internal_reset_a: assert property (resetPinOe |-> internalReset)
    else $error("Pin driven without internal reset");
  clocks_held_a: assert property (internalReset |-> !busClkEn)
    else $error("Bus clock runs in reset");
  enables_tied_a: assert property (periphClkEn == busClkEn
    && (!cpuClkEn || busClkEn)) else $error("Clock enables disagree");
  bus_divide_a: assert property (busClkEn |=> !busClkEn [*3])
    else $error("Bus enable too frequent");
  watchdog_gap_a: assert property (watchdogClkEn |=> !watchdogClkEn [*8])
    else $error("Watchdog clock too frequent");
  bad_opcode_a: assert property ($rose(badOpcode) && !internalReset
    |-> faultDrive) else $error("Bad opcode gave no reset");
  bad_fetch_a: assert property (opcodeFetch && unmappedAccess
    && !internalReset |-> faultDrive) else $error("Bad fetch ignored");
  pin_low_a: assert property (!resetPinIn |-> ##[1:3] internalReset)
    else $error("Low pin gave no reset");
  drive_length_a: assert property ($fell(resetPinOe)
    |-> oeCount >= 31 && oeCount <= POWER_ON_COUNT + 1)
    else $error("Pin drive length wrong");
  release_tail_a: assert property ($fell(resetPinOe) |-> releaseTail)
    else $error("Internal reset ended early");
  release_end_a: assert property ($fell(resetPinOe)
    |-> ##[1:100] !internalReset) else $error("Internal reset never ends");
endmodule : rcs_checker
bind rcs_reset_clock_sequencer rcs_checker #(
  .POWER_ON_COUNT(POWER_ON_COUNT)
) rcs_checker_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .badOpcode(badOpcode),
  .opcodeFetch(opcodeFetch), .unmappedAccess(unmappedAccess),
  .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
  .resetPinOe(resetPinOe), .busClkEn(busClkEn), .cpuClkEn(cpuClkEn),
  .periphClkEn(periphClkEn), .internalReset(internalReset),
  .watchdogClkEn(watchdogClkEn)
);

//--- rcs_board_model.sv
// Board model of the open-drain reset line and its pull-up.
`timescale 1ns/100ps
module rcs_board_model (
  // Pin drivers.
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic extPullLow,
  // Wire level.
  output logic resetPinIn
);
  // The pull-up wins whenever nobody pulls the line low.
  assign resetPinIn = !((resetPinOe && !resetPinOut) || extPullLow);
endmodule : rcs_board_model

//--- rcs_reset_clock_sequencer_tb.sv
// Testbench of the reset and clock sequencer.
`timescale 1ns/100ps
module rcs_reset_clock_sequencer_tb;
  logic refClk, resetN, extLow, pinIn, pinOut, pinOe, busEn, cpuEn, perEn;
  logic internal_reset, psel, penable, pwrite, pready, pslverr, err, a, b, cgen;
  logic [8:0] src;
  logic [15:0] vec, paddr;
  logic [31:0] pwdata, prdata, rd;
  int mismatches, checkCount, n, k;
  logic [8:0] srcs [6] = '{9'h100, 9'h020, 9'h001, 9'h002, 9'h00C, 9'h010};
  int bits [6] = '{7, 1, 4, 4, 3, 5};
  rcs_reset_clock_sequencer #(.POWER_ON_COUNT(40), .STOP_LONG_COUNT(40),
    .PIN_POWER_COUNT(107)) rcs_reset_clock_sequencer_inst (
    .ref_clk(refClk), .reset_n(resetN), .powerOnPulse(src[8]),
    .lowVoltageDetect(src[5]), .watchdogOverflow(src[4]),
    .badOpcode(src[0]), .stopInstr(src[1]), .waitInstr(src[6]),
    .wakeEvent(src[7]), .opcodeFetch(src[2]), .unmappedAccess(src[3]),
    .resetPinIn(pinIn), .resetPinOut(pinOut), .resetPinOe(pinOe),
    .clockGenEnable(cgen), .busClkEn(busEn), .cpuClkEn(cpuEn),
    .periphClkEn(perEn), .internalReset(internal_reset), .resetVector(vec),
    .watchdogClkEn(), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  rcs_board_model rcs_board_model_inst (.resetPinOut(pinOut),
    .resetPinOe(pinOe), .extPullLow(extLow), .resetPinIn(pinIn));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // Read data and the error flag are taken at the edge that sees pready.
  task automatic apb(input logic wr, input logic [15:0] ad,
      input logic [31:0] d);
    int t;
    @(posedge refClk);
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge refClk);
    penable <= 1;
    for (t = 0; t < 50; t++) begin
      @(posedge refClk);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        break;
      end
    end
    psel <= 0;
    penable <= 0;
    if (t == 50) begin
      mismatches++;
      stop_test();
    end
  endtask : apb
  task automatic pulse(input logic [8:0] v);
    @(posedge refClk);
    src <= v;
    @(posedge refClk);
    src <= '0;
  endtask : pulse
  task automatic countOe(output int c);
    @(negedge refClk);
    for (int t = 0; t < 8 && pinOe !== 1'b1; t++) @(negedge refClk);
    c = 0;
    while (pinOe === 1'b1 && c < 5000) begin
      @(negedge refClk);
      c++;
    end
  endtask : countOe
  task automatic waitRun;
    int t;
    for (t = 0; t < 3000 && internal_reset !== 1'b0; t++) @(negedge refClk);
    if (t == 3000) begin
      mismatches++;
      stop_test();
    end
  endtask : waitRun
  task automatic pinLow(input int c);
    @(posedge refClk);
    extLow <= 1;
    repeat (c) @(posedge refClk);
    extLow <= 0;
    waitRun();
    apb(0, rcs_pkg::ADDR_RESET_CAUSE, '0);
  endtask : pinLow
  ////////////////////////////////////////////////////////////////////////
  initial begin
    refClk = 0;
    forever #25 refClk = ~refClk;
  end
  initial begin
    {src, extLow, psel, penable, pwrite, resetN} = '0;
    paddr = '0;
    pwdata = '0;
    mismatches = 0;
    checkCount = 0;
    repeat (16) @(posedge refClk);
    resetN <= 1;
    countOe(k);
    check("porDrive", k, 40);
    waitRun();
    apb(0, rcs_pkg::ADDR_RESET_CAUSE, '0);
    check("porCause", rd, 32'h80);
    check("vector", vec, 32'hFFFE);
    check("clkGen", cgen, 1);
    // Disabled sources and a plain data fetch must leave the core running.
    apb(1, rcs_pkg::ADDR_CONFIG, 32'h07);
    pulse(9'h038);
    repeat (10) @(negedge refClk);
    check("noReset", internal_reset, 0);
    apb(1, rcs_pkg::ADDR_CONFIG, 32'h40);
    repeat (2) @(negedge refClk);
    check("monVector", vec, 32'hFEFE);
    for (n = 0; n < 6; n++) begin
      pulse(srcs[n]);
      countOe(k);
      check("pinDrive", k, (srcs[n][8] | srcs[n][5]) ? 40 : 32);
      waitRun();
      apb(0, rcs_pkg::ADDR_RESET_CAUSE, '0);
      check("cause", rd, 32'h1 << bits[n]);
      check("vecDefault", vec, 32'hFFFE);
    end
    pinLow(20);
    check("shortPin", rd, 32'h20);
    pinLow(70);
    check("longPin", rd, 32'h40);
    apb(1, rcs_pkg::ADDR_RESET_CAUSE, 32'hFF);
    apb(0, rcs_pkg::ADDR_RESET_CAUSE, '0);
    check("causeRo", rd, 32'h40);
    apb(0, 16'hFE02, '0);
    check("slvErr", {err, rd[30:0]}, 32'h80000000);
    for (n = 0; n < 2; n++) begin
      apb(1, rcs_pkg::ADDR_CONFIG, n ? 32'h10 : 32'h18);
      pulse(9'h002);
      repeat (8) @(posedge refClk);
      pulse(9'h080);
      for (k = 0; k < 200 && busEn !== 1'b1; k++) @(negedge refClk);
      check("stopDelay", k >= (n ? 38 : 30) && k <= (n ? 46 : 38), 1);
    end
    pulse(9'h040);
    {a, b} = '0;
    repeat (12) begin
      @(negedge refClk);
      a = a | cpuEn;
      b = b | perEn;
    end
    check("waitCpu", {a, b}, 32'h1);
    apb(0, rcs_pkg::ADDR_BREAK_STATUS, '0);
    check("waitFlag", rd[rcs_pkg::BREAK_WAIT_BIT], 1);
    pulse(9'h080);
    stop_test();
  end
endmodule : rcs_reset_clock_sequencer_tb
